// file: core/adc_seq_pkg.sv
// package: register map, field layout and types for the converter sequencer
package adc_seq_pkg;
  localparam logic [7:0] off_control_one = 8'h00;
  localparam logic [7:0] off_control_two = 8'h04;
  localparam logic [7:0] off_multi_sel   = 8'h08;
  localparam logic [7:0] off_scan_low    = 8'h0c;
  localparam logic [7:0] off_scan_high   = 8'h10;
  localparam logic [7:0] off_pin_cfg_a   = 8'h14;
  localparam logic [7:0] off_pin_cfg_b   = 8'h18;
  localparam logic [7:0] off_pin_digital = 8'h1c;
  localparam logic [7:0] off_result_base = 8'h40;
  localparam logic [7:0] off_fifo_data   = 8'h80;
  localparam logic [7:0] off_status      = 8'h84;
  localparam int done_bit         = 0;
  localparam int sample_start_bit = 1;
  localparam int twelve_bit_bit   = 10;
  localparam int dma_mode_bit     = 12;
  localparam int alt_mode_bit     = 0;
  localparam int spi_lsb          = 2;
  localparam int scan_enable_bit  = 10;
  localparam int neg_b_lsb        = 9;
  localparam int pos_b_bit        = 8;
  localparam int neg_a_lsb        = 1;
  localparam int pos_a_bit        = 0;
  localparam logic [15:0] multi_sel_mask = 16'h0707;
  localparam int result_count     = 16;
  localparam int fifo_depth       = 32;
  localparam int conv_cycles      = 14;
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_sample = 3'b010,
    st_conv   = 3'b100
  } conv_state_e;

  typedef struct packed {
    logic [1:0] neg_sel;
    logic       pos_sel;
  } input_sel_s;

  typedef struct packed {
    logic [4:0] pos_input;
    logic [4:0] neg_input;
  } route_s;
endpackage

// file: core/adc_result_fifo.sv
// result fifo with valid/ready on both sides
`timescale 1ns/1ps
module adc_result_fifo #(
  parameter int width = 16,
  parameter int depth = 32
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [width-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [width-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0]      wr_ptr;
  logic [aw:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (aw+1)'(depth);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[aw-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr[aw-1:0]] <= in_data;
    end
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// file: core/adc_seq_ctrl.sv
// converter sequencing, result storage and input routing with axi4-lite
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - after samples_per_interrupt+1 conversions the flag is set; irq only if enabled.
// - with channel_scan_enable set the scan list restarts at that same point.
// - without dma, results fill buffers 0..samples_per_interrupt in order; pointer wraps at that point.
// - with dma, one buffer is overwritten per result; reader must keep up.
// - done clears at conversion start or on a control_one write with it low, and sets at its end.
// - a shared pin is digital only when both config bits are one, else reads zero.
// - sample b negative select: 11 gives 9..11, 10 gives 6..8, 0x negative ref.
// - sample b positive select: one gives 3..5, zero gives 0..2.
// - in twelve-bit operation the select fields ignore writes and read zero.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module adc_seq_ctrl
  import adc_seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] conv_data,
  input  wire logic [15:0] pin_level,
  output logic [15:0]      digital_in_enable,
  output logic [4:0]       ch_pos_input [3],
  output logic [4:0]       ch_neg_input [3],
  output logic [3:0]       scan_index,
  output logic             conv_irq
);
  typedef struct packed {
    conv_state_e  state;
    logic [4:0]   timer;
    logic [15:0]  control_one;
    logic [15:0]  control_two;
    logic [15:0]  multi_sel;
    logic [15:0]  scan_low;
    logic [15:0]  pin_cfg_a;
    logic [15:0]  pin_cfg_b;
    logic [15:0]  digital;
    logic [3:0]   buf_ptr;
    logic [3:0]   conv_count;
    logic [3:0]   scan_pos;
    logic         alt_phase;
    logic         irq_flag;
    logic         irq_enable;
    logic         irq;
    logic         wr_aw;
    logic         wr_w;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [1:0]   rresp;
    logic [31:0]  rdata;
    route_s [2:0] route;
  } state_s;

  state_s      cur;
  state_s      next_cur;
  logic [15:0] results [result_count];
  logic        fifo_in_ready;
  logic [15:0] fifo_out_data;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic        conv_end;
  logic        wr_fire;
  logic [7:0]  rd_addr;
  input_sel_s  sel_now;

  assign conv_end = cur.state == st_conv && cur.timer == 5'(conv_cycles - 1);
  assign wr_fire  = cur.wr_aw && cur.wr_w && !cur.bvalid;
  assign rd_addr  = s_axi_araddr;
  assign fifo_pop = s_axi_arvalid && !cur.rvalid &&
                    rd_addr == off_fifo_data;

  // conversion results to software; full fifo stalls the next start
  adc_result_fifo #(.width(16), .depth(fifo_depth)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (conv_data),
    .in_valid  (conv_end),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // buffer array written in place; not part of the resettable state
  always_ff @(posedge aclk) begin
    if (conv_end) begin
      if (cur.control_one[dma_mode_bit]) begin
        results[0] <= conv_data;
      end else begin
        results[cur.buf_ptr] <= conv_data;
      end
    end
  end

  // routing for channels 0..2
  function automatic route_s route_of(input input_sel_s s, input int ch);
    route_s r;
    r.pos_input = s.pos_sel ? 5'(3 + ch) : 5'(ch);
    case (s.neg_sel)
      2'b11:   r.neg_input = 5'(9 + ch);
      2'b10:   r.neg_input = 5'(6 + ch);
      default: r.neg_input = 5'h1f; // negative reference
    endcase
    return r;
  endfunction

  always_comb begin
    next_cur = cur;
    sel_now = (cur.alt_phase && cur.control_two[alt_mode_bit]) ?
      input_sel_s'(cur.multi_sel[10:8]) :
      input_sel_s'(cur.multi_sel[2:0]);
    // unimplemented fields must not steer the inputs either
    if (cur.control_one[twelve_bit_bit]) begin
      sel_now = '0;
    end
    for (int ch = 0; ch < 3; ch++) begin
      next_cur.route[ch] = route_of(sel_now, ch);
    end
    // digital buffer enabled only when both converters agree
    next_cur.digital = pin_level & cur.pin_cfg_a & cur.pin_cfg_b;
    next_cur.irq = cur.irq_flag && cur.irq_enable;

    // conversion sequencer
    case (cur.state)
      st_idle: begin
        if (cur.control_one[sample_start_bit]) begin
          next_cur.state = st_sample;
        end
      end
      st_sample: begin
        // full result fifo holds the sample phase
        if (fifo_in_ready) begin
          next_cur.state = st_conv;
          next_cur.timer = '0;
          next_cur.control_one[done_bit] = 1'b0;
        end
      end
      st_conv: begin
        next_cur.timer = cur.timer + 5'd1;
        if (conv_end) begin
          next_cur.control_one[done_bit] = 1'b1;
          next_cur.control_one[sample_start_bit] = 1'b0;
          next_cur.alt_phase = !cur.alt_phase;
          next_cur.state = st_idle;
          if (cur.conv_count == cur.control_two[spi_lsb +: 4]) begin
            next_cur.conv_count = '0;
            next_cur.irq_flag = 1'b1;
            next_cur.buf_ptr = '0;
            next_cur.alt_phase = 1'b0;
            if (cur.control_two[scan_enable_bit]) begin
              next_cur.scan_pos = '0;
            end
          end else begin
            next_cur.conv_count = cur.conv_count + 4'd1;
            next_cur.buf_ptr = cur.buf_ptr + 4'd1;
            if (cur.control_two[scan_enable_bit]) begin
              next_cur.scan_pos = cur.scan_pos + 4'd1;
            end
          end
        end
      end
      default: next_cur.state = st_idle;
    endcase

    // write channel
    if (s_axi_awvalid && !cur.wr_aw) begin
      next_cur.wr_aw = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.wr_w) begin
      next_cur.wr_w = 1'b1;
      next_cur.w_data = s_axi_wdata;
    end
    if (wr_fire) begin
      next_cur.wr_aw = 1'b0;
      next_cur.wr_w = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = resp_okay;
      case (cur.aw_addr)
        off_control_one: begin
          // done set by a conversion end beats the software write
          next_cur.control_one = cur.w_data[15:0];
          if (conv_end) begin
            next_cur.control_one[done_bit] = 1'b1;
          end
        end
        off_control_two: next_cur.control_two = cur.w_data[15:0];
        off_multi_sel: begin
          if (!cur.control_one[twelve_bit_bit]) begin
            next_cur.multi_sel = cur.w_data[15:0] & multi_sel_mask;
          end
        end
        off_scan_low:  next_cur.scan_low = cur.w_data[15:0];
        off_pin_cfg_a: next_cur.pin_cfg_a = cur.w_data[15:0];
        off_pin_cfg_b: next_cur.pin_cfg_b = cur.w_data[15:0];
        off_status: begin
          next_cur.irq_enable = cur.w_data[1];
          // write one clears; a new event in the same cycle wins
          if (cur.w_data[0] && !(conv_end &&
              cur.conv_count == cur.control_two[spi_lsb +: 4])) begin
            next_cur.irq_flag = 1'b0;
          end
        end
        default: next_cur.bresp = resp_slverr;
      endcase
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end

    // read channel
    if (s_axi_arvalid && !cur.rvalid) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = resp_okay;
      next_cur.rdata = '0;
      if (rd_addr >= off_result_base &&
          rd_addr < off_result_base + 8'(4 * result_count) &&
          rd_addr[1:0] == 2'b00) begin
        next_cur.rdata = {16'h0000, results[rd_addr[5:2]]};
      end else begin
        case (rd_addr)
          off_control_one: next_cur.rdata = {16'h0000, cur.control_one};
          off_control_two: next_cur.rdata = {16'h0000, cur.control_two};
          off_multi_sel: next_cur.rdata = cur.control_one[twelve_bit_bit] ?
            32'h00000000 : {16'h0000, cur.multi_sel};
          off_scan_low:    next_cur.rdata = {16'h0000, cur.scan_low};
          off_scan_high:   next_cur.rdata = 32'h00000000;
          off_pin_cfg_a:   next_cur.rdata = {16'h0000, cur.pin_cfg_a};
          off_pin_cfg_b:   next_cur.rdata = {16'h0000, cur.pin_cfg_b};
          off_pin_digital: next_cur.rdata = {16'h0000, cur.digital};
          off_fifo_data: next_cur.rdata = {15'h0000, fifo_out_valid,
                                           fifo_out_data};
          off_status: next_cur.rdata = {24'h000000, cur.buf_ptr,
                                        2'b00, cur.irq_enable, cur.irq_flag};
          default: next_cur.rresp = resp_slverr;
        endcase
      end
    end
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.state <= st_idle;
      cur.route <= {3{route_s'({5'h00, 5'h1f})}};
    end else begin
      cur <= next_cur;
    end
  end

  assign s_axi_awready = !cur.wr_aw;
  assign s_axi_wready  = !cur.wr_w;
  assign s_axi_bvalid  = cur.bvalid;
  assign s_axi_bresp   = cur.bresp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_rvalid  = cur.rvalid;
  assign s_axi_rresp   = cur.rresp;
  assign s_axi_rdata   = cur.rdata;
  assign digital_in_enable = cur.digital;
  assign scan_index    = cur.scan_pos;
  assign conv_irq      = cur.irq;
  for (genvar g = 0; g < 3; g++) begin : g_route
    assign ch_pos_input[g] = cur.route[g].pos_input;
    assign ch_neg_input[g] = cur.route[g].neg_input;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_conv_done;
    cur.state == st_conv ##1 cur.state == st_idle;
  endsequence

  sequence s_wrap_point;
    conv_end && cur.conv_count == cur.control_two[spi_lsb +: 4];
  endsequence

  a_done_sets: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_conv_done |-> cur.control_one[done_bit])
    else $error("done not set after conversion");
  a_done_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(cur.control_one[done_bit]) |-> cur.state == st_conv ||
    $past(wr_fire))
    else $error("done cleared outside conversion start");
  a_done_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cur.control_one[done_bit] && cur.state == st_idle && !wr_fire
    |=> cur.control_one[done_bit])
    else $error("done dropped before the next conversion");
  a_irq_gated: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_irq |-> $past(cur.irq_enable) && $past(cur.irq_flag))
    else $error("interrupt without enable");
  a_ptr_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wrap_point |=> cur.buf_ptr == 4'h0 && cur.irq_flag)
    else $error("buffer pointer did not wrap");
  a_scan_restart: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_end && cur.control_two[scan_enable_bit] &&
    cur.conv_count == cur.control_two[spi_lsb +: 4]
    |=> scan_index == 4'h0)
    else $error("scan list did not restart");
  a_dma_single: assert property (
    @(posedge aclk) disable iff (!aresetn)
    conv_end && cur.control_one[dma_mode_bit]
    |=> results[0] == $past(conv_data))
    else $error("dma result not in the single buffer");
  a_pin_digital: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(cur.pin_cfg_a[0] && cur.pin_cfg_b[0]) |=> !digital_in_enable[0])
    else $error("digital input enabled by one converter");
  a_neg_map: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sel_now.neg_sel == 2'b11 |=> ch_neg_input[2] == 5'd11)
    else $error("negative input map wrong");
  a_pos_map: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sel_now.pos_sel |=> ch_pos_input[0] == 5'd3)
    else $error("positive input map wrong");
  a_alt_select: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cur.control_two[alt_mode_bit] && !cur.control_one[twelve_bit_bit] &&
    cur.multi_sel[pos_a_bit] |=> ch_pos_input[1] == 5'd4)
    else $error("sample a select not applied");
  a_twelve_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cur.control_one[twelve_bit_bit] && !$past(wr_fire)
    |=> $stable(cur.multi_sel))
    else $error("select changed in twelve-bit mode");
endmodule

// file: verif/adc_front_model.sv
// analog front end model: converter results and shared pin levels
`timescale 1ns/1ps
module adc_front_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] sample_value,
  output logic [15:0]      conv_data,
  output logic [15:0]      pin_level
);
  // result is registered, so it follows sample_value one cycle later on every edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_data <= 16'h0000;
    end else begin
      conv_data <= sample_value;
    end
  end
  // fixed mixed pattern so both gating levels show on the pins
  assign pin_level = 16'ha5c3;
endmodule

// file: verif/adc_sequencing_channel_select_test.sv
// self-checking bench for the converter sequencer register interface
`timescale 1ns/1ps
module adc_sequencing_channel_select_test;
  import adc_seq_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready, conv_irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, ctl1;
  logic [3:0]  wstrb, scan_index;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] conv_data, pin_level, dig_en, sample_value;
  logic [4:0]  ch_pos [3];
  logic [4:0]  ch_neg [3];
  int          err_count, samples_checked;

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  adc_front_model model (.aclk(aclk), .aresetn(aresetn),
    .sample_value(sample_value), .conv_data(conv_data),
    .pin_level(pin_level));

  adc_seq_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_data(conv_data),
    .pin_level(pin_level), .digital_in_enable(dig_en),
    .ch_pos_input(ch_pos), .ch_neg_input(ch_neg),
    .scan_index(scan_index), .conv_irq(conv_irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stall();
    err_count++;
    $display("[ERR] handshake expected answer seen none");
    report_and_stop();
  endtask

  // each task starts on a fresh edge so no signal is driven twice per step
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
      n++;
      if (n > 100) stall();
    end
    bready <= 1'b0;
    rsp = bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
      n++;
      if (n > 100) stall();
    end
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask

  task automatic route_chk(input logic [1:0] n, input logic p);
    for (int i = 0; i < 3; i++) begin
      check("pos route", {27'h0, ch_pos[i]}, p ? 32'(3 + i) : 32'(i));
      check("neg route", {27'h0, ch_neg[i]},
            n[1] ? 32'((n[0] ? 9 : 6) + i) : 32'd31);
    end
  endtask

  // start is written with done low, as polling software must do
  task automatic conv(input logic [15:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    sample_value <= v;
    axw(off_control_one, ctl1 | 32'h2);
    axr(off_control_one);
    check("done at start", {31'h0, rd[done_bit]}, 32'h0);
    while (rd[done_bit] !== 1'b1) begin
      axr(off_control_one);
      n++;
      if (n > 50) stall();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    sample_value = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    ctl1 = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // route leaves its reset value only at the first edge out of reset
    repeat (2) @(posedge aclk);
    route_chk(2'b00, 1'b0);
    axr(off_multi_sel);
    check("sel reset", rd, 32'h0);
    // sample b fields set opposite, so any use of them shows on the route
    for (int k = 0; k < 8; k++) begin
      axw(off_multi_sel, {21'h0, ~k[2:1], ~k[0], 5'h0, k[2:1], k[0]});
      repeat (2) @(posedge aclk);
      route_chk(k[2:1], k[0]);
    end
    axw(off_multi_sel, 32'hffff);
    axr(off_multi_sel);
    check("sel mask", rd, {16'h0, multi_sel_mask});
    axw(off_control_one, 32'(1) << twelve_bit_bit);
    axw(off_multi_sel, 32'h0303);
    axr(off_multi_sel);
    check("sel twelve", rd, 32'h0);
    axr(8'hfc);
    check("unmapped", {30'h0, rsp}, {30'h0, resp_slverr});
    axw(off_pin_cfg_a, 32'hffff);
    axw(off_pin_cfg_b, 32'h00ff);
    repeat (2) @(posedge aclk);
    check("dig enable", {16'h0, dig_en}, 32'h00c3);
    axr(off_pin_digital);
    check("dig read", rd, 32'h00c3);
    // two conversions per flag and per buffer wrap
    axw(off_control_two, 32'(1) << spi_lsb);
    conv(16'h1234);
    conv(16'h5678);
    axr(off_result_base);
    check("buf0", rd, 32'h1234);
    axr(off_result_base + 8'h04);
    check("buf1", rd, 32'h5678);
    axr(off_status);
    check("flag", rd & 32'h3, 32'h1);
    check("irq masked", {31'h0, conv_irq}, 32'h0);
    axw(off_status, 32'h2);
    repeat (2) @(posedge aclk);
    check("irq on", {31'h0, conv_irq}, 32'h1);
    axw(off_status, 32'h3);
    repeat (2) @(posedge aclk);
    check("irq clear", {31'h0, conv_irq}, 32'h0);
    conv(16'h9abc);
    axr(off_result_base);
    check("buf wrap", rd, 32'h9abc);
    repeat (20) @(posedge aclk);
    axr(off_control_one);
    check("done held", {31'h0, rd[done_bit]}, 32'h1);
    ctl1 = 32'(1) << dma_mode_bit;
    conv(16'h0f0f);
    conv(16'hf0f0);
    axr(off_result_base);
    check("dma buf", rd, 32'hf0f0);
    ctl1 = 32'h0;
    // ignored twelve-bit write left the earlier selects in place
    axr(off_multi_sel);
    check("sel kept", rd, {16'h0, multi_sel_mask});
    // alternate mode: a right after a wrap, b on the next sample
    axw(off_multi_sel, 32'h0502);
    axw(off_control_two, 32'h405);
    conv(16'h1111);
    route_chk(2'b01, 1'b0);
    check("scan wrap", {28'h0, scan_index}, 32'h0);
    conv(16'h2222);
    route_chk(2'b10, 1'b1);
    check("scan step", {28'h0, scan_index}, 32'h1);
    // empty the fifo, fill it to depth, then drain it in order
    rd = 32'h1_0000;
    for (int k = 0; k < 40 && rd[16] === 1'b1; k++) axr(off_fifo_data);
    check("fifo empty", rd & 32'h1_0000, 32'h0);
    for (int k = 0; k < fifo_depth; k++) conv(16'h0a00 + 16'(k));
    for (int k = 0; k < fifo_depth; k++) begin
      axr(off_fifo_data);
      check("fifo pop", rd, {15'h0, 1'b1, 16'h0a00 + 16'(k)});
    end
    axr(off_fifo_data);
    check("fifo drained", rd & 32'h1_0000, 32'h0);
    report_and_stop();
  end
endmodule
